// *** src/mrtm_cfg.svh ***
// timing constants and error codes for the motor ready timeout monitor
`ifndef MRTM_CFG_SVH
`define MRTM_CFG_SVH
`define MRTM_CLK_HZ 40000000
`define MRTM_TICK_MS 1
`define MRTM_TICK_CYC ((`MRTM_CLK_HZ / 1000) * `MRTM_TICK_MS)
`define MRTM_STEADY_MS 1000
`define MRTM_START_MS 2000
`define MRTM_POLY_START_MS 10000
`define MRTM_CODE_NONE 16'h0000
`define MRTM_CODE_MAIN_STEADY 16'd2000
`define MRTM_CODE_MAIN_START 16'd2010
`define MRTM_CODE_FEED2_START 16'd2600
`define MRTM_CODE_FEED3_START 16'd2610
`define MRTM_CODE_POLY_START 16'd4000
`define MRTM_CODE_POLY_STEADY 16'd4010
`endif

// *** src/mrtm_motor_watch.sv ***
// one motor's start-up and steady-state ready watcher
`timescale 1ns/1ps
`default_nettype none
module mrtm_motor_watch
   import mrtm_pkg::*;
#(
   parameter int START_MS = 2000,
   parameter int STEADY_MS = 1000,
   parameter bit HAS_STEADY = 1'b1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // tick
   mrtm_tick_if.dst tk,
   // motor
   input wire logic run,
   input wire logic ready,
   // result
   output logic start_err,
   output logic steady_err
);
   logic [13:0] ms_q;
   mrtm_state_e st_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_q <= MRTM_IDLE;
      end else begin
         unique case (st_q)
            // ready already present at start counts as stabilised, so a short pulse is not lost
            MRTM_IDLE: if (run) st_q <= ready ? MRTM_STEADY : MRTM_STARTING;
            MRTM_STARTING: begin
               if (!run) st_q <= MRTM_IDLE;
               else if (ready) st_q <= MRTM_STEADY;
               else if (tk.tick && ms_q >= 14'(START_MS - 1)) st_q <= MRTM_FAILED;
            end
            MRTM_STEADY: begin
               if (!run) st_q <= MRTM_IDLE;
               else if (HAS_STEADY && !ready && tk.tick && ms_q >= 14'(STEADY_MS - 1)) st_q <= MRTM_FAILED;
            end
            MRTM_FAILED: st_q <= MRTM_FAILED;
         endcase
      end
   end

   // counter restarts on stop or on ready
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) ms_q <= '0;
      else if (!run || ready || st_q == MRTM_IDLE || st_q == MRTM_FAILED) ms_q <= '0;
      else if (tk.tick) ms_q <= ms_q + 14'd1;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         start_err <= 1'b0;
         steady_err <= 1'b0;
      end else begin
         if (st_q == MRTM_STARTING && run && !ready && tk.tick && ms_q >= 14'(START_MS - 1))
            start_err <= 1'b1;
         if (HAS_STEADY && st_q == MRTM_STEADY && run && !ready && tk.tick && ms_q >= 14'(STEADY_MS - 1))
            steady_err <= 1'b1;
      end
   end

   a_err_sticky: assert property (@(posedge sys_clk) disable iff (rst) start_err |=> start_err)
      else $error("start error dropped");
endmodule : mrtm_motor_watch
`default_nettype wire

// *** src/mrtm_pkg.sv ***
// types shared by the motor ready timeout monitor
package mrtm_pkg;
   typedef logic [15:0] mrtm_code_t;
   typedef enum logic [1:0] {MRTM_IDLE, MRTM_STARTING, MRTM_STEADY, MRTM_FAILED} mrtm_state_e;
endpackage : mrtm_pkg

// *** src/mrtm_tick_if.sv ***
// millisecond tick shared between the top and the per-motor watchers
`timescale 1ns/1ps
`default_nettype none
interface mrtm_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input tick);
endinterface : mrtm_tick_if
`default_nettype wire

// *** src/mrtm_top.sv ***
// motor ready timeout monitor: top level
// What this block does
// - main motor steady: ready absent 1 s continuously raises code 2000
// - main motor start: ready unseen 2 s after start raises code 2010
// - cassette 2 feeder motor: ready unseen within 2 s raises code 2600
// - cassette 3 feeder motor: ready unseen within 2 s raises code 2610
// - polygon motor start: ready unseen 10 s after start raises 4000
// - polygon motor steady: ready absent 1 s continuously raises code 4010
`include "mrtm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mrtm_top
   import mrtm_pkg::*;
#(
   parameter int TICK_CYC = `MRTM_TICK_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // motor run commands
   input wire logic main_run,
   input wire logic paper_feeder2_run,
   input wire logic paper_feeder3_run,
   input wire logic laser_scanner_unit_run,
   // ready feedback from drivers
   input wire logic main_ready,
   input wire logic paper_feeder2_ready,
   input wire logic paper_feeder3_ready,
   input wire logic laser_scanner_unit_ready,
   // error report
   output logic err_valid_q,
   output mrtm_pkg::mrtm_code_t err_code_q,
   output logic [5:0] err_flags_q
);
   import mrtm_pkg::*;

   // ---------------------------------
   // millisecond tick
   // ---------------------------------
   mrtm_tick_if tk ();
   logic [31:0] div_q;
   logic tick_q;
   // tick kept as a flop so every watcher sees the same edge
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else if (div_q == 32'(TICK_CYC - 1)) begin
         div_q <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 32'd1;
         tick_q <= 1'b0;
      end
   end
   assign tk.tick = tick_q;

   // ---------------------------------
   // per-motor watchers
   // ---------------------------------
   logic [3:0] run_v, rdy_v, st_err, sd_err;
   assign run_v = {laser_scanner_unit_run, paper_feeder3_run, paper_feeder2_run, main_run};
   assign rdy_v = {laser_scanner_unit_ready, paper_feeder3_ready, paper_feeder2_ready, main_ready};

   localparam int START_TBL [4] = '{`MRTM_START_MS, `MRTM_START_MS, `MRTM_START_MS, `MRTM_POLY_START_MS};
   localparam bit STEADY_TBL [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_mot
         mrtm_motor_watch #(
            .START_MS(START_TBL[gi]),
            .STEADY_MS(`MRTM_STEADY_MS),
            .HAS_STEADY(STEADY_TBL[gi])
         ) u_watch (
            .sys_clk(sys_clk),
            .rst(rst),
            .tk(tk),
            .run(run_v[gi]),
            .ready(rdy_v[gi]),
            .start_err(st_err[gi]),
            .steady_err(sd_err[gi])
         );
      end
   endgenerate

   // ---------------------------------
   // error latch
   // ---------------------------------
   // flag order: 0 main steady, 1 main start, 2 feeder2, 3 feeder3, 4 poly start, 5 poly steady
   logic [5:0] flags;
   assign flags = {sd_err[3], st_err[3], st_err[2], st_err[1], st_err[0], sd_err[0]};

   function automatic mrtm_code_t code_of(input logic [5:0] f);
      mrtm_code_t c;
      c = `MRTM_CODE_NONE;
      if (f[5]) c = `MRTM_CODE_POLY_STEADY;
      if (f[4]) c = `MRTM_CODE_POLY_START;
      if (f[3]) c = `MRTM_CODE_FEED3_START;
      if (f[2]) c = `MRTM_CODE_FEED2_START;
      if (f[1]) c = `MRTM_CODE_MAIN_START;
      if (f[0]) c = `MRTM_CODE_MAIN_STEADY;
      return c;
   endfunction : code_of

   // first error wins the code; later ones still show in the flags
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         err_valid_q <= 1'b0;
         err_code_q <= `MRTM_CODE_NONE;
         err_flags_q <= '0;
      end else begin
         err_flags_q <= err_flags_q | flags;
         if (!err_valid_q && flags != 6'h00) begin
            err_valid_q <= 1'b1;
            err_code_q <= code_of(flags);
         end
      end
   end

   // ---------------------------------
   // shadow timers for the checks
   // ---------------------------------
   // counted apart from the watchers so a wrong limit inside them cannot hide
   logic [13:0] shadow_q [4];
   logic [3:0] seen_q;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int m = 0; m < 4; m++) begin
            shadow_q[m] <= '0;
         end
      end else begin
         for (int m = 0; m < 4; m++) begin
            if (!run_v[m] || rdy_v[m]) shadow_q[m] <= '0;
            else if (tk.tick && shadow_q[m] != '1) shadow_q[m] <= shadow_q[m] + 14'd1;
         end
      end
   end

   // a motor counts as stabilised from the first ready seen while it runs
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         seen_q <= '0;
      end else begin
         seen_q <= run_v & (seen_q | rdy_v);
      end
   end

   // ---------------------------------
   // checks
   // ---------------------------------
   // the deciding sample lies two edges before a flag rises
   a_code_stable: assert property (@(posedge sys_clk) disable iff (rst)
      err_valid_q |=> err_valid_q && $stable(err_code_q))
      else $error("latched code changed");
   a_main_start: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(err_flags_q[1]) |-> $past(main_run, 2) && !$past(main_ready, 2))
      else $error("main start error without stalled motor");
   a_main_steady: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(err_flags_q[0]) |-> !$past(main_ready, 2))
      else $error("main steady error while ready");
   a_feed2_start: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(err_flags_q[2]) |-> $past(paper_feeder2_run, 2) && !$past(paper_feeder2_ready, 2))
      else $error("feeder 2 error without stalled motor");
   a_feed3_start: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(err_flags_q[3]) |-> $past(paper_feeder3_run, 2) && !$past(paper_feeder3_ready, 2))
      else $error("feeder 3 error without stalled motor");
   a_poly_start: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(err_flags_q[4]) |-> $past(laser_scanner_unit_run, 2) && !$past(laser_scanner_unit_ready, 2))
      else $error("polygon start error without stalled motor");
   a_poly_steady: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(err_flags_q[5]) |-> !$past(laser_scanner_unit_ready, 2))
      else $error("polygon steady error while ready");
   a_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
      err_flags_q[0] |=> err_flags_q[0])
      else $error("flag dropped");
   a_code_match: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(err_valid_q) |-> err_code_q != `MRTM_CODE_NONE)
      else $error("valid without code");

   // ---------------------------------
   // limit checks against the shadow timers
   // ---------------------------------
   a_main_start_early: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(err_flags_q[1]) |-> $past(shadow_q[0], 2) >= 14'(`MRTM_START_MS - 1))
      else $error("main start error before its limit");
   a_main_start_late: assert property (@(posedge sys_clk) disable iff (rst)
      !seen_q[0] && shadow_q[0] >= 14'(`MRTM_START_MS + 2) && !err_flags_q[0] |-> err_flags_q[1])
      else $error("main start error missing");
   a_main_steady_early: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(err_flags_q[0]) |-> $past(shadow_q[0], 2) >= 14'(`MRTM_STEADY_MS - 1))
      else $error("main steady error before its limit");
   a_main_steady_late: assert property (@(posedge sys_clk) disable iff (rst)
      seen_q[0] && shadow_q[0] >= 14'(`MRTM_STEADY_MS + 2) && !err_flags_q[1] |-> err_flags_q[0])
      else $error("main steady error missing");
   a_feed2_early: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(err_flags_q[2]) |-> $past(shadow_q[1], 2) >= 14'(`MRTM_START_MS - 1))
      else $error("feeder 2 error before its limit");
   a_feed2_late: assert property (@(posedge sys_clk) disable iff (rst)
      !seen_q[1] && shadow_q[1] >= 14'(`MRTM_START_MS + 2) |-> err_flags_q[2])
      else $error("feeder 2 error missing");
   a_feed3_early: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(err_flags_q[3]) |-> $past(shadow_q[2], 2) >= 14'(`MRTM_START_MS - 1))
      else $error("feeder 3 error before its limit");
   a_feed3_late: assert property (@(posedge sys_clk) disable iff (rst)
      !seen_q[2] && shadow_q[2] >= 14'(`MRTM_START_MS + 2) |-> err_flags_q[3])
      else $error("feeder 3 error missing");
   a_poly_start_early: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(err_flags_q[4]) |-> $past(shadow_q[3], 2) >= 14'(`MRTM_POLY_START_MS - 1))
      else $error("polygon start error before its limit");
   a_poly_start_late: assert property (@(posedge sys_clk) disable iff (rst)
      !seen_q[3] && shadow_q[3] >= 14'(`MRTM_POLY_START_MS + 2) && !err_flags_q[5] |-> err_flags_q[4])
      else $error("polygon start error missing");
   a_poly_steady_early: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(err_flags_q[5]) |-> $past(shadow_q[3], 2) >= 14'(`MRTM_STEADY_MS - 1))
      else $error("polygon steady error before its limit");
   a_poly_steady_late: assert property (@(posedge sys_clk) disable iff (rst)
      seen_q[3] && shadow_q[3] >= 14'(`MRTM_STEADY_MS + 2) && !err_flags_q[4] |-> err_flags_q[5])
      else $error("polygon steady error missing");

   c_main_start: cover property (@(posedge sys_clk) disable iff (rst) $rose(err_flags_q[1]));
   c_main_steady: cover property (@(posedge sys_clk) disable iff (rst) $rose(err_flags_q[0]));
   c_poly_start: cover property (@(posedge sys_clk) disable iff (rst) $rose(err_flags_q[4]));
   c_feed2: cover property (@(posedge sys_clk) disable iff (rst) $rose(err_flags_q[2]));
   c_poly_steady: cover property (@(posedge sys_clk) disable iff (rst) $rose(err_flags_q[5]));
endmodule : mrtm_top
`default_nettype wire

// *** verification/mrtm_drv_model.sv ***
// motor driver stand-in: ready follows run after spin-up, per mode
`timescale 1ns/1ps
`default_nettype none
module mrtm_drv_model (
   // clock
   input wire logic sys_clk,
   // control
   input wire logic run,
   input wire logic [1:0] mode,
   // feedback
   output logic ready
);
   int n;
   // mode 0 healthy, 1 never ready, 2 ready then lost for good
   always_ff @(posedge sys_clk) begin
      n <= run ? n + 1 : 0;
      ready <= run && mode != 2'h1 && n >= 10 && !(mode == 2'h2 && n >= 210);
   end
endmodule : mrtm_drv_model
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the motor ready timeout monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mrtm_pkg::*;
   typedef struct {logic [7:0] md; int quiet; mrtm_code_t code; logic [5:0] flg;} mrtm_row_s;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] run = 4'h0;
   wire logic [3:0] rdy;
   logic [7:0] md = 8'h00;
   logic err_valid_q;
   mrtm_code_t err_code_q;
   logic [5:0] err_flags_q;
   int err_total = 0;
   int n_compared = 0;
   int cyc = 0;
   // modes per motor {scanner, feeder3, feeder2, main}; quiet is cycles with no error expected
   // the third row stalls both feeders together, so the lower code must win
   mrtm_row_s rows [6] = '{'{8'h01, 7900, 16'd2010, 6'h02}, '{8'h04, 7900, 16'd2600, 6'h04},
      '{8'h14, 7900, 16'd2600, 6'h0c}, '{8'h40, 39800, 16'd4000, 6'h10},
      '{8'h02, 4100, 16'd2000, 6'h01}, '{8'h80, 4100, 16'd4010, 6'h20}};
   always #12.5 sys_clk = ~sys_clk;
   mrtm_top #(.TICK_CYC(4)) mrtm_top_i (.sys_clk(sys_clk), .rst(rst), .main_run(run[0]),
      .paper_feeder2_run(run[1]), .paper_feeder3_run(run[2]), .laser_scanner_unit_run(run[3]),
      .main_ready(rdy[0]), .paper_feeder2_ready(rdy[1]), .paper_feeder3_ready(rdy[2]),
      .laser_scanner_unit_ready(rdy[3]), .err_valid_q(err_valid_q), .err_code_q(err_code_q),
      .err_flags_q(err_flags_q));
   for (genvar g = 0; g < 4; g++) begin : g_drv
      mrtm_drv_model mrtm_drv_model_i (.sys_clk(sys_clk), .run(run[g]), .mode(md[2*g +: 2]), .ready(rdy[g]));
   end
   task automatic summarize;
      $display("compared %0d, wrong %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize
   task automatic cmp_code(mrtm_code_t got, mrtm_code_t exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: code %0d not %0d", $time, got, exp);
      end
   endtask : cmp_code
   task automatic cmp_bits(logic [5:0] got, logic [5:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: bits %b not %b", $time, got, exp);
      end
   endtask : cmp_bits
   task automatic restart;
      @(posedge sys_clk);
      rst <= 1'b1;
      run <= 4'h0;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
   endtask : restart
   // checks happen at the falling edge so registered outputs have settled
   task automatic hold(int n);
      repeat (n) @(negedge sys_clk);
   endtask : hold
   task automatic await(int lim);
      for (int k = 0; k < lim && err_valid_q !== 1'b1; k++) @(negedge sys_clk);
      cmp_bits({5'h00, err_valid_q}, 6'h01);
   endtask : await
   // a hang is cut short well above the expected run length
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      restart();
      hold(1);
      cmp_bits(err_flags_q, 6'h00);
      cmp_bits({5'h00, err_valid_q}, 6'h00);
      cmp_code(err_code_q, 16'h0000);
      $display("test reset done");
      foreach (rows[i]) begin
         restart();
         md <= rows[i].md;
         run <= 4'hf;
         hold(rows[i].quiet);
         cmp_bits(err_flags_q, 6'h00);
         await(400);
         cmp_code(err_code_q, rows[i].code);
         cmp_bits(err_flags_q, rows[i].flg);
         @(posedge sys_clk);
         run <= 4'h0;
         hold(50);
         cmp_bits(err_flags_q, rows[i].flg);
         $display("test %0d done", i);
      end
      // main is stopped mid start-up and restarted; feeder3 fails first and its code is kept
      restart();
      md <= 8'h11;
      run <= 4'h5;
      hold(3000);
      @(posedge sys_clk);
      run <= 4'h4;
      @(posedge sys_clk);
      run <= 4'h5;
      hold(4850);
      await(400);
      cmp_bits(err_flags_q, 6'h08);
      hold(2700);
      cmp_bits(err_flags_q, 6'h08);
      await(1);
      hold(600);
      cmp_bits(err_flags_q, 6'h0a);
      cmp_code(err_code_q, 16'd2610);
      restart();
      hold(1);
      cmp_bits(err_flags_q, 6'h00);
      cmp_bits({5'h00, err_valid_q}, 6'h00);
      cmp_code(err_code_q, 16'h0000);
      $display("test restart and latch done");
      summarize();
   end
endmodule : testbench
`default_nettype wire
